// ===== bert_error_inject_and_sync.sv
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none

module bert_error_inject_and_sync
	import bert_pkg::*;
#(
	parameter int LOAD_BITS  = LOAD_BITS_DEF,
	parameter int TRIAL_BITS = TRIAL_BITS_DEF,
	parameter int WIN_BITS   = WIN_BITS_DEF,
	parameter int DWELL_BITS = DWELL_BITS_DEF
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic      [31:0] reg_rdata,
	input  wire logic        rx_data_pin,
	output logic      [1:0]  tx_data,
	output taps_t     [1:0]  tx_taps,
	output logic      [16:0] sj_head,
	output logic      [16:0] dly_head,
	output logic      [7:0]  sample_threshold_voltage,
	output logic      [7:0]  decision_delay
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// an all-zero window would lock the sequence, so a one is forced in
	function automatic logic prbs_fb(input logic [30:0] s, input logic [1:0] sel);
		case (sel)
			2'h0:    prbs_fb = (s[6] ^ s[5]) | ~|s[6:0];
			2'h1:    prbs_fb = (s[14] ^ s[13]) | ~|s[14:0];
			2'h2:    prbs_fb = (s[22] ^ s[17]) | ~|s[22:0];
			default: prbs_fb = (s[30] ^ s[27]) | ~|s[30:0];
		endcase
	endfunction : prbs_fb

	function automatic logic [29:0] ratio_period(input logic [3:0] e);
		case (e)
			4'h4:    ratio_period = 30'h0000270f;
			4'h5:    ratio_period = 30'h0001869f;
			4'h6:    ratio_period = 30'h000f423f;
			4'h7:    ratio_period = 30'h0098967f;
			4'h8:    ratio_period = 30'h05f5e0ff;
			4'h9:    ratio_period = 30'h3b9ac9ff;
			default: ratio_period = 30'h000003e7;
		endcase
	endfunction : ratio_period

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	gen_ctrl_t  gw;
	chk_ctrl_t  cw;
	logic       wr_gen, wr_taps, wr_sjc, wr_sjh, wr_dlc, wr_dlh, wr_chk;
	logic       wr_lim, wr_step, wr_dec;
	logic       rd_ch;

	assign gw      = gen_ctrl_t'(reg_wdata);
	assign cw      = chk_ctrl_t'(reg_wdata);
	assign wr_gen  = reg_we && reg_addr == GEN_CTRL_ADDR;
	assign wr_taps = reg_we && reg_addr == TAPS_ADDR;
	assign wr_sjc  = reg_we && reg_addr == SJ_CTL_ADDR;
	assign wr_sjh  = reg_we && reg_addr == SJ_HEAD_ADDR;
	assign wr_dlc  = reg_we && reg_addr == DLY_CTL_ADDR;
	assign wr_dlh  = reg_we && reg_addr == DLY_HEAD_ADDR;
	assign wr_chk  = reg_we && reg_addr == CHK_CTRL_ADDR;
	assign wr_lim  = reg_we && reg_addr == LIMIT_ADDR;
	assign wr_step = reg_we && reg_addr == STEP_ADDR;
	assign wr_dec  = reg_we && reg_addr == DEC_ADDR;

	// ----------------------------------------------------------------
	// generator configuration
	// ----------------------------------------------------------------
	logic      [1:0]  chan_q;
	gen_ctrl_t [1:0]  gcfg_q;
	taps_t     [1:0]  taps_q;
	logic      [15:0] sj_ctl_q;
	logic      [15:0] dly_ctl_q;

	assign rd_ch = ~chan_q[0];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chan_q    <= CHAN_RST;
			gcfg_q    <= {2{GEN_CTRL_RST}};
			taps_q    <= '0;
			sj_ctl_q  <= '0;
			dly_ctl_q <= '0;
		end else begin
			if (reg_we && reg_addr == CHAN_ADDR)
				chan_q <= reg_wdata[1:0];
			for (int c = 0; c < 2; c++) begin
				if (wr_gen && chan_q[c]) begin
					gcfg_q[c].ratio_on  <= gw.ratio_on;
					gcfg_q[c].pattern   <= gw.pattern;
					// out-of-range exponents are held at the nearest end
					gcfg_q[c].ratio_exp <= (gw.ratio_exp < EXP_MIN) ? EXP_MIN :
						(gw.ratio_exp > EXP_MAX) ? EXP_MAX : gw.ratio_exp;
				end
				if (wr_taps && chan_q[c])
					taps_q[c] <= taps_t'({8'h00, reg_wdata[23:0]});
			end
			if (wr_sjc && chan_q[0])
				sj_ctl_q <= reg_wdata[15:0];
			else if (wr_sjh && chan_q[0])
				sj_ctl_q <= reg_wdata[16:1];
			if (wr_dlc && chan_q[1])
				dly_ctl_q <= reg_wdata[15:0];
			else if (wr_dlh && chan_q[1])
				dly_ctl_q <= reg_wdata[16:1];
		end
	end

	// ----------------------------------------------------------------
	// pattern generators with error insertion
	// ----------------------------------------------------------------
	logic [1:0][30:0] lfsr_q;
	logic [1:0][29:0] ratio_cnt_q;
	logic [1:0]       one_shot_q;
	logic [1:0]       gen_fb;
	logic [1:0]       ratio_hit;
	logic [1:0]       inject;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			gen_fb[c]    = prbs_fb(lfsr_q[c], gcfg_q[c].pattern);
			ratio_hit[c] = gcfg_q[c].ratio_on && ratio_cnt_q[c] == ratio_period(gcfg_q[c].ratio_exp);
			inject[c]    = one_shot_q[c] | ratio_hit[c];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lfsr_q      <= {2{31'h7fffffff}};
			ratio_cnt_q <= '0;
			one_shot_q  <= '0;
			tx_data     <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				lfsr_q[c]     <= {lfsr_q[c][29:0], gen_fb[c]};
				tx_data[c]    <= gen_fb[c] ^ inject[c];
				one_shot_q[c] <= wr_gen && chan_q[c] && gw.one_shot;
				if (!gcfg_q[c].ratio_on || ratio_hit[c])
					ratio_cnt_q[c] <= '0;
				else
					ratio_cnt_q[c] <= ratio_cnt_q[c] + 30'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_taps  <= '0;
			sj_head  <= '0;
			dly_head <= '0;
		end else begin
			tx_taps  <= taps_q;
			sj_head  <= {sj_ctl_q, 1'b0};
			dly_head <= {dly_ctl_q, 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// checker control
	// ----------------------------------------------------------------
	chk_ctrl_t  cctl_q;
	logic       sync_now_q, run_q;
	logic [15:0] limit_q;
	logic [7:0]  tstep_q, dstep_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cctl_q     <= chk_ctrl_t'(CHK_CTRL_RST);
			sync_now_q <= 1'b0;
			run_q      <= 1'b0;
			limit_q    <= LIMIT_RST;
			tstep_q    <= STEP_RST;
			dstep_q    <= STEP_RST;
		end else begin
			sync_now_q <= wr_chk && cw.sync_now;
			run_q      <= wr_chk && cw.run_align;
			if (wr_chk) begin
				cctl_q           <= cw;
				cctl_q.sync_now  <= 1'b0;
				cctl_q.run_align <= 1'b0;
				cctl_q.clear     <= 1'b0;
				cctl_q.rsvd      <= '0;
				if (cw.auto_pat)
					cctl_q.pat_class <= 1'b0;
			end
			if (wr_lim)
				limit_q <= reg_wdata[15:0];
			if (wr_step) begin
				tstep_q <= reg_wdata[7:0];
				dstep_q <= reg_wdata[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// receive path and synchronisation
	// ----------------------------------------------------------------
	logic        rx_meta_q, rx_q;
	sync_st_t    st_q;
	logic [30:0] ref_q;
	logic [15:0] cnt_q, err_q;
	logic [1:0]  try_pat_q, det_pat_q;
	logic        unknown_q;
	logic [1:0]  chk_pat;
	logic        exp_fb, mismatch;
	logic [15:0] err_nx;

	assign chk_pat  = cctl_q.auto_pat ? try_pat_q : cctl_q.pattern;
	assign exp_fb   = prbs_fb(ref_q, chk_pat);
	assign mismatch = exp_fb ^ rx_q;
	assign err_nx   = err_q + {15'h0000, mismatch};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_meta_q <= 1'b0;
			rx_q      <= 1'b0;
		end else begin
			rx_meta_q <= rx_data_pin;
			rx_q      <= rx_meta_q;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q      <= ST_IDLE;
			ref_q     <= '0;
			cnt_q     <= '0;
			err_q     <= '0;
			try_pat_q <= '0;
			det_pat_q <= '0;
			unknown_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (sync_now_q || !cctl_q.manual) begin
						st_q  <= ST_LOAD;
						cnt_q <= '0;
					end
				end
				ST_LOAD: begin
					// seed the reference straight from the line
					ref_q <= {ref_q[29:0], rx_q};
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q == 16'(LOAD_BITS - 1)) begin
						st_q  <= ST_TRIAL;
						cnt_q <= '0;
						err_q <= '0;
					end
				end
				ST_TRIAL: begin
					ref_q <= {ref_q[29:0], exp_fb};
					cnt_q <= cnt_q + 16'h0001;
					err_q <= err_nx;
					if (cnt_q == 16'(TRIAL_BITS - 1)) begin
						cnt_q <= '0;
						err_q <= '0;
						if (err_nx == 16'h0000) begin
							st_q      <= ST_LOCK;
							det_pat_q <= chk_pat;
							unknown_q <= 1'b0;
						end else begin
							st_q <= cctl_q.manual ? ST_IDLE : ST_LOAD;
							if (cctl_q.auto_pat) begin
								try_pat_q <= try_pat_q + 2'h1;
								if (try_pat_q == 2'h3)
									unknown_q <= 1'b1;
							end
						end
					end
				end
				ST_LOCK: begin
					ref_q <= {ref_q[29:0], exp_fb};
					cnt_q <= cnt_q + 16'h0001;
					err_q <= err_nx;
					if (sync_now_q) begin
						st_q  <= ST_LOAD;
						cnt_q <= '0;
					end else if (!cctl_q.manual && err_nx >= limit_q) begin
						st_q  <= ST_LOAD;
						cnt_q <= '0;
					end else if (cnt_q == 16'(WIN_BITS - 1)) begin
						cnt_q <= '0;
						err_q <= '0;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// accumulated statistics
	// ----------------------------------------------------------------
	logic [31:0] err_cnt_q, bit_cnt_q, time_cnt_q;
	logic [7:0]  tick_q;
	logic        stat_clear;

	// clearing a running accumulation is ignored
	assign stat_clear = wr_chk && cw.clear && !cw.accum && !cctl_q.accum;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			err_cnt_q  <= '0;
			bit_cnt_q  <= '0;
			time_cnt_q <= '0;
			tick_q     <= '0;
		end else if (stat_clear) begin
			err_cnt_q  <= '0;
			bit_cnt_q  <= '0;
			time_cnt_q <= '0;
			tick_q     <= '0;
		end else if (cctl_q.accum) begin
			tick_q <= (tick_q == 8'(TICK_CYC - 1)) ? 8'h00 : tick_q + 8'h01;
			if (tick_q == 8'(TICK_CYC - 1))
				time_cnt_q <= time_cnt_q + 32'h1;
			if (st_q == ST_LOCK) begin
				bit_cnt_q <= bit_cnt_q + 32'h1;
				err_cnt_q <= err_cnt_q + {31'h0, mismatch};
			end
		end
	end

	// ----------------------------------------------------------------
	// decision point alignment
	// ----------------------------------------------------------------
	align_st_t  al_q;
	logic [7:0] pos_q, first_q, last_q, saved_q, eye_h_q, eye_w_q;
	logic [15:0] dwell_q;
	logic       derr_q, found_q, dwell_end;
	logic [8:0] pos_nx;
	logic [7:0] step_cur, mid;
	logic       pt_ok, found_nx;
	logic [7:0] first_nx, last_nx;

	assign dwell_end = dwell_q == 16'(DWELL_BITS - 1);
	assign step_cur  = (al_q == AL_THR) ? tstep_q : dstep_q;
	assign pos_nx    = {1'b0, pos_q} + {1'b0, step_cur};
	// the point just finished must count, or the last open point drops out of the eye
	assign pt_ok     = !(derr_q | mismatch | (st_q != ST_LOCK));
	assign found_nx  = found_q | pt_ok;
	assign first_nx  = (pt_ok && !found_q) ? pos_q : first_q;
	assign last_nx   = pt_ok ? pos_q : last_q;
	assign mid       = 8'(({1'b0, first_nx} + {1'b0, last_nx}) >> 1);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			al_q                     <= AL_IDLE;
			sample_threshold_voltage <= THR_RST;
			decision_delay           <= DLY_RST;
			{pos_q, first_q, last_q, saved_q} <= '0;
			{eye_h_q, eye_w_q}       <= '0;
			dwell_q                  <= '0;
			{derr_q, found_q}        <= '0;
		end else begin
			case (al_q)
				AL_IDLE: begin
					// pattern writes never touch these values
					if (wr_dec) begin
						sample_threshold_voltage <= reg_wdata[7:0];
						decision_delay           <= reg_wdata[15:8];
					end
					if (run_q && (cctl_q.thr_en || cctl_q.dly_en)) begin
						al_q    <= cctl_q.thr_en ? AL_THR : AL_DLY;
						saved_q <= cctl_q.thr_en ? sample_threshold_voltage : decision_delay;
						if (cctl_q.thr_en)
							sample_threshold_voltage <= '0;
						else
							decision_delay <= '0;
						{pos_q, dwell_q, derr_q, found_q} <= '0;
					end
				end
				AL_THR, AL_DLY: begin
					dwell_q <= dwell_q + 16'h0001;
					derr_q  <= derr_q | mismatch | (st_q != ST_LOCK);
					if (dwell_end) begin
						dwell_q <= '0;
						derr_q  <= 1'b0;
						first_q <= first_nx;
						last_q  <= last_nx;
						found_q <= found_nx;
						// a zero step would never finish the sweep
						if (pos_nx[8] || step_cur == 8'h00) begin
							if (al_q == AL_THR) begin
								sample_threshold_voltage <= found_nx ? mid : saved_q;
								eye_h_q <= found_nx ? last_nx - first_nx : 8'h00;
							end else begin
								decision_delay <= found_nx ? mid : saved_q;
								eye_w_q        <= found_nx ? last_nx - first_nx : 8'h00;
							end
							if (al_q == AL_THR && cctl_q.dly_en) begin
								al_q           <= AL_DLY;
								saved_q        <= decision_delay;
								decision_delay <= '0;
								{pos_q, found_q} <= '0;
							end else
								al_q <= AL_IDLE;
						end else begin
							pos_q <= pos_nx[7:0];
							if (al_q == AL_THR)
								sample_threshold_voltage <= pos_nx[7:0];
							else
								decision_delay <= pos_nx[7:0];
						end
					end
				end
				default: al_q <= AL_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	status_t status;

	always_comb begin
		status         = '0;
		status.in_sync = st_q == ST_LOCK;
		status.unknown = unknown_q;
		status.busy    = al_q != AL_IDLE;
		status.det_pat = det_pat_q;
		status.eye_h   = eye_h_q;
		status.eye_w   = eye_w_q;
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !reg_re) begin
			reg_rdata <= '0;
		end else begin
			case (reg_addr)
				CHAN_ADDR:     reg_rdata <= {30'h0, chan_q};
				GEN_CTRL_ADDR: reg_rdata <= gcfg_q[rd_ch];
				TAPS_ADDR:     reg_rdata <= taps_q[rd_ch];
				SJ_CTL_ADDR:   reg_rdata <= {16'h0, sj_ctl_q};
				SJ_HEAD_ADDR:  reg_rdata <= {15'h0, sj_ctl_q, 1'b0};
				DLY_CTL_ADDR:  reg_rdata <= {16'h0, dly_ctl_q};
				DLY_HEAD_ADDR: reg_rdata <= {15'h0, dly_ctl_q, 1'b0};
				CHK_CTRL_ADDR: reg_rdata <= cctl_q;
				LIMIT_ADDR:    reg_rdata <= {16'h0, limit_q};
				STEP_ADDR:     reg_rdata <= {16'h0, dstep_q, tstep_q};
				DEC_ADDR:      reg_rdata <= {16'h0, decision_delay, sample_threshold_voltage};
				STATUS_ADDR:   reg_rdata <= status;
				ERRCNT_ADDR:   reg_rdata <= err_cnt_q;
				BITCNT_ADDR:   reg_rdata <= bit_cnt_q;
				TIMECNT_ADDR:  reg_rdata <= time_cnt_q;
				default:       reg_rdata <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_one_shot_flip: assert property (@(posedge clk) disable iff (sys_rst)
		wr_gen && chan_q[0] && gw.one_shot |=> ##1 tx_data[0] != $past(gen_fb[0]))
		else $error("single error not inserted on channel 0");
	a_no_spurious_flip: assert property (@(posedge clk) disable iff (sys_rst)
		!inject[1] |=> tx_data[1] == $past(gen_fb[1]))
		else $error("channel 1 bit changed without an injection");
	a_jitter_head_x2: assert property (@(posedge clk) disable iff (sys_rst)
		wr_sjh && chan_q[0] |-> ##2 sj_head == {$past(reg_wdata[16:1], 2), 1'b0})
		else $error("head jitter amplitude not twice controller value");
	a_delay_chan_only: assert property (@(posedge clk) disable iff (sys_rst)
		(wr_dlc || wr_dlh) && !chan_q[1] && !$past(sys_rst) |=> $stable(dly_ctl_q))
		else $error("delay changed through a channel list without channel 1");
	a_auto_default: assert property (@(posedge clk)
		$fell(sys_rst) |-> !cctl_q.manual && cctl_q.thr_en && cctl_q.dly_en)
		else $error("checker did not come up in automatic mode");
	a_manual_waits: assert property (@(posedge clk) disable iff (sys_rst)
		st_q == ST_IDLE && cctl_q.manual && !sync_now_q |=> st_q == ST_IDLE)
		else $error("manual mode started a sync without a command");
	a_auto_resync: assert property (@(posedge clk) disable iff (sys_rst)
		st_q == ST_LOCK && !cctl_q.manual && err_nx >= limit_q |=> st_q == ST_LOAD)
		else $error("error limit reached without resync");
	a_error_count: assert property (@(posedge clk) disable iff (sys_rst)
		cctl_q.accum && st_q == ST_LOCK && mismatch && !stat_clear |=> err_cnt_q == $past(err_cnt_q) + 32'h1)
		else $error("mismatch not counted");
	a_clear_zeroes: assert property (@(posedge clk) disable iff (sys_rst)
		stat_clear |=> err_cnt_q == 32'h0 && bit_cnt_q == 32'h0 && time_cnt_q == 32'h0)
		else $error("statistics not cleared");
	a_auto_pat_prbs: assert property (@(posedge clk) disable iff (sys_rst)
		wr_chk && cw.auto_pat |=> !cctl_q.pat_class)
		else $error("auto detect did not force the PRBS class");

endmodule : bert_error_inject_and_sync

`default_nettype wire

// ===== bert_pkg.sv
package bert_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ   = 25;
	localparam int TICK_NS   = 1000;
	localparam int TICK_CYC  = (TICK_NS * CLK_MHZ + 999) / 1000;
	localparam int LOAD_BITS_DEF  = 32;
	localparam int TRIAL_BITS_DEF = 64;
	localparam int WIN_BITS_DEF   = 1024;
	localparam int DWELL_BITS_DEF = 32;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CHAN_ADDR     = 8'h00;
	localparam logic [7:0] GEN_CTRL_ADDR = 8'h04;
	localparam logic [7:0] TAPS_ADDR     = 8'h08;
	localparam logic [7:0] SJ_CTL_ADDR   = 8'h0c;
	localparam logic [7:0] SJ_HEAD_ADDR  = 8'h10;
	localparam logic [7:0] DLY_CTL_ADDR  = 8'h14;
	localparam logic [7:0] DLY_HEAD_ADDR = 8'h18;
	localparam logic [7:0] CHK_CTRL_ADDR = 8'h20;
	localparam logic [7:0] LIMIT_ADDR    = 8'h24;
	localparam logic [7:0] STEP_ADDR     = 8'h28;
	localparam logic [7:0] DEC_ADDR      = 8'h2c;
	localparam logic [7:0] STATUS_ADDR   = 8'h30;
	localparam logic [7:0] ERRCNT_ADDR   = 8'h34;
	localparam logic [7:0] BITCNT_ADDR   = 8'h38;
	localparam logic [7:0] TIMECNT_ADDR  = 8'h3c;

	// ----------------------------------------------------------------
	// reset values and exponent limits
	// ----------------------------------------------------------------
	localparam logic [1:0]  CHAN_RST     = 2'h1;
	localparam logic [31:0] GEN_CTRL_RST = 32'h0000_3000;
	localparam logic [31:0] CHK_CTRL_RST = 32'h0000_00c0;
	localparam logic [15:0] LIMIT_RST    = 16'h0010;
	localparam logic [7:0]  STEP_RST     = 8'h04;
	localparam logic [7:0]  THR_RST      = 8'h80;
	localparam logic [7:0]  DLY_RST      = 8'h00;
	localparam logic [3:0]  EXP_MIN      = 4'h3;
	localparam logic [3:0]  EXP_MAX      = 4'h9;

	// ----------------------------------------------------------------
	// field layouts and state encodings
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] rsvd_hi;
		logic [3:0]  ratio_exp;
		logic [6:0]  rsvd_lo;
		logic        one_shot;
		logic        rsvd_b;
		logic [1:0]  pattern;
		logic        ratio_on;
	} gen_ctrl_t;

	typedef struct packed {
		logic [20:0] rsvd;
		logic        clear;
		logic        accum;
		logic        run_align;
		logic        dly_en;
		logic        thr_en;
		logic        auto_pat;
		logic        sync_now;
		logic        manual;
		logic        pat_class;
		logic [1:0]  pattern;
	} chk_ctrl_t;

	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] post2;
		logic [7:0] post1;
		logic [7:0] pre;
	} taps_t;

	typedef struct packed {
		logic [7:0] rsvd_hi;
		logic [7:0] eye_w;
		logic [7:0] eye_h;
		logic [2:0] rsvd_lo;
		logic [1:0] det_pat;
		logic       busy;
		logic       unknown;
		logic       in_sync;
	} status_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_LOAD  = 4'b0010,
		ST_TRIAL = 4'b0100,
		ST_LOCK  = 4'b1000
	} sync_st_t;

	typedef enum logic [2:0] {
		AL_IDLE = 3'b001,
		AL_THR  = 3'b010,
		AL_DLY  = 3'b100
	} align_st_t;

endpackage : bert_pkg

// ===== bert_loopback.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// loopback device at the far side
// ----------------------------------------
module bert_loopback #(
	parameter int LAT = 1
) (
	input  wire logic clk,
	input  wire logic tx_bit,
	output logic      rx_bit
);
	// a non-uniform start value keeps the first returned bits from looking like a pattern
	logic [7:0] pipe_q = 8'h5a;

	always_ff @(posedge clk) begin
		pipe_q <= {pipe_q[6:0], tx_bit};
	end

	// each sent bit comes back untouched LAT cycles later
	assign rx_bit = pipe_q[LAT-1];
endmodule : bert_loopback

`default_nettype wire

// ===== bert_error_inject_and_sync_test.sv
`timescale 1ns/1ns
`default_nettype none

module bert_error_inject_and_sync_test;
	import bert_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_we = 1'b0;
	logic        reg_re = 1'b0;
	logic [31:0] reg_rdata;
	logic        rx_bit;
	logic [1:0]  tx_data;
	taps_t [1:0] tx_taps;
	logic [16:0] sj_head;
	logic [16:0] dly_head;
	logic [7:0]  thr_v;
	logic [7:0]  dly_v;
	logic [31:0] d;
	logic [31:0] e0;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	initial forever #20 clk = ~clk;

	bert_error_inject_and_sync #(.WIN_BITS(64), .DWELL_BITS(8)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .rx_data_pin(rx_bit),
		.tx_data(tx_data), .tx_taps(tx_taps), .sj_head(sj_head), .dly_head(dly_head),
		.sample_threshold_voltage(thr_v), .decision_delay(dly_v));

	bert_loopback i_far (.clk(clk), .tx_bit(tx_data[0]), .rx_bit(rx_bit));

	// ----------------------------------------
	// bus and report tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_we    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_re   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] x);
		rd(a, d);
		chk(n, x, d);
	endtask : rchk

	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// the tests need about 7000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			stop_test();
		end
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rchk("chk_ctrl", CHK_CTRL_ADDR, 32'h0000_00c0);
		rchk("dec", DEC_ADDR, 32'h0000_0080);
		wr(CHK_CTRL_ADDR, 32'h0000_00c0);
		d = '0;
		for (int i = 0; i < 400 && d[0] !== 1'b1; i++)
			rd(STATUS_ADDR, d);
		chk("in_sync", 32'h1, {31'h0, d[0]});
		$display("test reset_sync done");
		wr(CHK_CTRL_ADDR, 32'h0000_02c0);
		rd(ERRCNT_ADDR, e0);
		wr(GEN_CTRL_ADDR, 32'h0000_3010);
		repeat (8) @(posedge clk);
		rchk("one_shot", ERRCNT_ADDR, e0 + 1);
		wr(GEN_CTRL_ADDR, 32'h0000_3001);
		repeat (5000) @(posedge clk);
		wr(GEN_CTRL_ADDR, 32'h0000_3000);
		rd(ERRCNT_ADDR, d);
		chk("ratio", 32'h1, {31'h0, (d >= e0 + 5 && d <= e0 + 7)});
		wr(CHK_CTRL_ADDR, 32'h0000_00c0);
		wr(CHK_CTRL_ADDR, 32'h0000_04c0);
		rchk("err_clr", ERRCNT_ADDR, 32'h0);
		rchk("bit_clr", BITCNT_ADDR, 32'h0);
		rchk("time_clr", TIMECNT_ADDR, 32'h0);
		$display("test errors done");
		wr(SJ_HEAD_ADDR, 32'h0000_0400);
		rchk("sj_ctl", SJ_CTL_ADDR, 32'h0000_0200);
		wr(DLY_CTL_ADDR, 32'h0000_0077);
		rchk("dly_blk", DLY_CTL_ADDR, 32'h0);
		wr(SJ_CTL_ADDR, 32'h0000_0100);
		rchk("sj_head", SJ_HEAD_ADDR, 32'h0000_0200);
		chk("sj_pin", 32'h200, {15'h0, sj_head});
		wr(CHAN_ADDR, 32'h2);
		wr(DLY_HEAD_ADDR, 32'h0000_00a0);
		rchk("dly_ctl", DLY_CTL_ADDR, 32'h0000_0050);
		chk("dly_pin", 32'h0a0, {15'h0, dly_head});
		wr(SJ_CTL_ADDR, 32'h0000_0300);
		wr(TAPS_ADDR, 32'h0003_0201);
		repeat (3) @(posedge clk);
		chk("sj_kept", 32'h200, {15'h0, sj_head});
		chk("taps_ch1", 32'h0003_0201, tx_taps[1]);
		chk("taps_ch0", 32'h0, tx_taps[0]);
		$display("test channels done");
		wr(DEC_ADDR, 32'h0000_1234);
		repeat (3) @(posedge clk);
		chk("dec_pins", 32'h1234, {16'h0, dly_v, thr_v});
		wr(CHK_CTRL_ADDR, 32'h0000_00c3);
		rchk("dec_kept", DEC_ADDR, 32'h0000_1234);
		rchk("unmapped", 8'hfc, 32'h0);
		$display("test decision done");
		repeat (100) @(posedge clk);
		wr(CHK_CTRL_ADDR, 32'h0000_00cb);
		repeat (200) @(posedge clk);
		rchk("manual_idle", STATUS_ADDR, 32'h0);
		wr(CHK_CTRL_ADDR, 32'h0000_00d8);
		repeat (150) @(posedge clk);
		rchk("manual_sync", STATUS_ADDR, 32'h1);
		wr(CHK_CTRL_ADDR, 32'h0000_01c8);
		d = 32'h4;
		for (int i = 0; i < 1000 && d[2] !== 1'b0; i++)
			rd(STATUS_ADDR, d);
		chk("eye", 32'h00fc_fc01, d);
		rchk("aligned", DEC_ADDR, 32'h0000_7e7e);
		wr(CHK_CTRL_ADDR, 32'h0000_00e4);
		rchk("auto_pat", CHK_CTRL_ADDR, 32'h0000_00e0);
		$display("test sync and alignment done");
		stop_test();
	end
endmodule : bert_error_inject_and_sync_test

`default_nettype wire
